// File: inc/accum_map.svh
// Constants of the accumulator datapath: register indices, fields, resets, shift limits.
// Assumes inclusion by bare name from the datapath and the bench files.
`ifndef ACCUM_MAP_SVH
`define ACCUM_MAP_SVH

// ----------------------------------------
// Register indices on the plain port
// ----------------------------------------
`define REG_CONTROL 4'h0
`define REG_STATUS 4'h1
`define REG_ACC_LO 4'h2
`define REG_ACC_HI 4'h3
`define REG_PROD_LO 4'h4
`define REG_PROD_HI 4'h5
`define REG_TEMP 4'h6

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTL_SIGN_EXT_BIT 0
`define CTL_PROD_SHIFT_LSB 1
`define STS_CARRY_BIT 0
`define STS_SELECT_LSB 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_SIGN_EXT 1'h1
`define RST_PROD_SHIFT 2'h0
`define RST_ACC 32'h0000_0000
`define RST_PROD 32'h0000_0000
`define RST_TEMP 16'h0000
`define RST_PC 16'h0000
`define RST_SELECT 3'h0
`define RST_PTR 16'h0000

// ----------------------------------------
// Shift limits and product shift amounts
// ----------------------------------------
`define SHIFT1_MAX 5'h10
`define SHIFT2_MAX 5'h0f
`define PROD_SHIFT0 5'h00
`define PROD_SHIFT1 5'h01
`define PROD_SHIFT2 5'h04
`define PROD_SHIFT3 5'h00

`endif

// File: inc/accum_pkg.sv
// Types shared by the accumulator datapath and its helpers.
// Assumes the decoder drives one instruction struct per issue.
package accum_pkg;

   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      MAGNITUDE_OP = 4'h1,
      SUM_SHIFT_OP = 4'h2,
      SUM_WITH_CARRY_OP = 4'h3,
      SUM_UPPER_HALF_OP = 4'h4,
      SUM_SHORT_IMMEDIATE_OP = 4'h5,
      SUM_UNSIGNED_OP = 4'h6,
      SUM_VARIABLE_SHIFT_OP = 4'h7,
      SUM_LONG_IMMEDIATE_OP = 4'h8,
      POINTER_INCREMENT_OP = 4'h9,
      MASK_OP = 4'ha,
      MASK_LONG_IMMEDIATE_OP = 4'hb,
      PRODUCT_ACCUMULATE_OP = 4'hc,
      BRANCH_OP = 4'hd
   } op_type;

   typedef enum logic [2:0] {
      IND_KEEP = 3'h0,
      IND_INC = 3'h1,
      IND_DEC = 3'h2,
      IND_ADD0 = 3'h3,
      IND_SUB0 = 3'h4,
      IND_BR_ADD0 = 3'h5,
      IND_BR_SUB0 = 3'h6,
      IND_SPARE = 3'h7
   } ind_mode_type;

   typedef struct packed {
      op_type op;
      logic use_imm;
      logic [15:0] mem_data;
      logic [15:0] imm;
      logic [4:0] shift;
      logic ind_en;
      ind_mode_type ind_mode;
      logic select_load;
      logic [2:0] next_select;
      logic [15:0] target;
   } instr_type;

endpackage : accum_pkg

// File: logic/operand_shifter.sv
// Left shifter for a 16-bit operand into a 32-bit field.
// Assumes the count is already limited by the caller.
`timescale 1ns/1ns
`default_nettype none
module operand_shifter #(
   parameter int W = 16
) (
   input wire logic [W-1:0] data,
   input wire logic [4:0] count,
   input wire logic sign_ext,
   output logic [31:0] shifted
);
   logic [31:0] widened;

   always_comb begin
      widened = {{(32-W){sign_ext & data[W-1]}}, data};
      shifted = widened << count;
   end
endmodule : operand_shifter
`default_nettype wire

// File: logic/pointer_step.sv
// Next value of the current pointer register for one indirect operand mode.
// Assumes index register zero is supplied by the caller.
`timescale 1ns/1ns
`default_nettype none
module pointer_step (
   input wire logic [15:0] value,
   input wire logic [15:0] index0,
   input wire accum_pkg::ind_mode_type mode,
   output logic [15:0] stepped
);
   function automatic logic [15:0] rev16(input logic [15:0] v);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         r[i] = v[15-i];
      end
      return r;
   endfunction : rev16

   // Bit-reversed steps carry from the top bit downward, which suits FFT tables.
   always_comb begin
      case (mode)
         accum_pkg::IND_INC: stepped = value + 16'h0001;
         accum_pkg::IND_DEC: stepped = value - 16'h0001;
         accum_pkg::IND_ADD0: stepped = value + index0;
         accum_pkg::IND_SUB0: stepped = value - index0;
         accum_pkg::IND_BR_ADD0: stepped = rev16(rev16(value) + rev16(index0));
         accum_pkg::IND_BR_SUB0: stepped = rev16(rev16(value) - rev16(index0));
         default: stepped = value;
      endcase
   end
endmodule : pointer_step
`default_nettype wire

// File: logic/accumulator_arith_logic_datapath.sv
// Accumulator datapath: add, AND, magnitude, product accumulate, branch and pointer steps.
// Assumes the decoder issues one instruction struct per op_valid pulse on clk_sys.
`include "accum_map.svh"
`timescale 1ns/1ns
`default_nettype none
module accumulator_arith_logic_datapath #(
   parameter int POINTERS = 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic op_valid,
   input wire accum_pkg::instr_type instr,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata_r,
   output logic [31:0] acc_r,
   output logic carry_r,
   output logic [15:0] pc_r,
   output logic [2:0] current_pointer_select_r,
   output logic done_r
);
   // ----------------------------------------
   // Software registers
   // ----------------------------------------
   logic sign_extend_enable_r, sign_extend_enable_nxt;
   logic [1:0] product_shift_select_r, product_shift_select_nxt;
   logic [31:0] prod_r, prod_nxt;
   logic [15:0] temp_r, temp_nxt;
   logic [31:0] reg_rdata_nxt;

   always_comb begin
      sign_extend_enable_nxt = sign_extend_enable_r;
      product_shift_select_nxt = product_shift_select_r;
      prod_nxt = prod_r;
      temp_nxt = temp_r;
      reg_rdata_nxt = 32'h0000_0000;
      if (reg_wr) begin
         case (reg_addr)
            `REG_CONTROL: begin
               sign_extend_enable_nxt = reg_wdata[`CTL_SIGN_EXT_BIT];
               product_shift_select_nxt = reg_wdata[`CTL_PROD_SHIFT_LSB +: 2];
            end
            `REG_PROD_LO: prod_nxt[15:0] = reg_wdata[15:0];
            `REG_PROD_HI: prod_nxt[31:16] = reg_wdata[15:0];
            `REG_TEMP: temp_nxt = reg_wdata[15:0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            `REG_CONTROL: begin
               reg_rdata_nxt[`CTL_SIGN_EXT_BIT] = sign_extend_enable_r;
               reg_rdata_nxt[`CTL_PROD_SHIFT_LSB +: 2] = product_shift_select_r;
            end
            `REG_STATUS: begin
               reg_rdata_nxt[`STS_CARRY_BIT] = carry_r;
               reg_rdata_nxt[`STS_SELECT_LSB +: 3] = current_pointer_select_r;
            end
            `REG_ACC_LO: reg_rdata_nxt[15:0] = acc_r[15:0];
            `REG_ACC_HI: reg_rdata_nxt[15:0] = acc_r[31:16];
            `REG_PROD_LO: reg_rdata_nxt[15:0] = prod_r[15:0];
            `REG_PROD_HI: reg_rdata_nxt[15:0] = prod_r[31:16];
            `REG_TEMP: reg_rdata_nxt[15:0] = temp_r;
            default: reg_rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sign_extend_enable_r <= `RST_SIGN_EXT;
         product_shift_select_r <= `RST_PROD_SHIFT;
         prod_r <= `RST_PROD;
         temp_r <= `RST_TEMP;
         reg_rdata_r <= 32'h0000_0000;
      end else begin
         sign_extend_enable_r <= sign_extend_enable_nxt;
         product_shift_select_r <= product_shift_select_nxt;
         prod_r <= prod_nxt;
         temp_r <= temp_nxt;
         reg_rdata_r <= reg_rdata_nxt;
      end
   end

   // ----------------------------------------
   // Operand shifting
   // ----------------------------------------
   logic [4:0] shift1, shift2, shift_sel, prod_shift_amt;
   logic [15:0] shift_src;
   logic shift_sx;
   logic [31:0] shifted;

   always_comb begin
      // Counts in instr.shift above the legal range saturate rather than wrap.
      shift1 = (instr.shift > `SHIFT1_MAX) ? `SHIFT1_MAX : instr.shift;
      shift2 = (instr.shift > `SHIFT2_MAX) ? `SHIFT2_MAX : instr.shift;
      shift_src = instr.use_imm ? instr.imm : instr.mem_data;
      shift_sx = sign_extend_enable_r;
      shift_sel = shift1;
      case (instr.op)
         accum_pkg::SUM_LONG_IMMEDIATE_OP: begin
            shift_src = instr.imm;
            shift_sel = shift2;
         end
         accum_pkg::SUM_VARIABLE_SHIFT_OP: begin
            shift_src = instr.mem_data;
            shift_sel = {1'b0, temp_r[3:0]};
         end
         accum_pkg::MASK_LONG_IMMEDIATE_OP: begin
            shift_src = instr.imm;
            shift_sx = 1'b0;
         end
         accum_pkg::MASK_OP: shift_sx = 1'b0;
         default: ;
      endcase
      case (product_shift_select_r)
         2'h1: prod_shift_amt = `PROD_SHIFT1;
         2'h2: prod_shift_amt = `PROD_SHIFT2;
         2'h3: prod_shift_amt = `PROD_SHIFT3;
         default: prod_shift_amt = `PROD_SHIFT0;
      endcase
   end

   operand_shifter #(.W(16)) u_shift (
      .data(shift_src),
      .count(shift_sel),
      .sign_ext(shift_sx),
      .shifted(shifted)
   );

   // ----------------------------------------
   // Pointer bank
   // ----------------------------------------
   logic [15:0] pointer_register_bank [POINTERS];
   logic [15:0] cur_ptr, stepped;
   logic ptr_we;
   logic [15:0] ptr_wval;

   assign cur_ptr = pointer_register_bank[current_pointer_select_r];

   pointer_step u_step (
      .value(cur_ptr),
      .index0(pointer_register_bank[0]),
      .mode(instr.ind_mode),
      .stepped(stepped)
   );

   generate
      for (genvar i = 0; i < POINTERS; i++) begin : g_ptr
         logic [15:0] ptr_nxt;
         assign ptr_nxt = (ptr_we && current_pointer_select_r == i) ?
                          ptr_wval : pointer_register_bank[i];
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               pointer_register_bank[i] <= `RST_PTR;
            end else begin
               pointer_register_bank[i] <= ptr_nxt;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Execute
   // ----------------------------------------
   logic [31:0] acc_nxt;
   logic carry_nxt;
   logic [15:0] pc_nxt;
   logic [2:0] current_pointer_select_nxt;
   logic [32:0] sum;
   logic [16:0] hi_sum;
   logic [31:0] mem_sx;

   assign mem_sx = {{16{sign_extend_enable_r & instr.mem_data[15]}}, instr.mem_data};

   always_comb begin
      acc_nxt = acc_r;
      carry_nxt = carry_r;
      pc_nxt = pc_r;
      current_pointer_select_nxt = current_pointer_select_r;
      ptr_we = 1'b0;
      ptr_wval = cur_ptr;
      sum = 33'h0_0000_0000;
      hi_sum = 17'h0_0000;
      if (op_valid) begin
         case (instr.op)
            accum_pkg::MAGNITUDE_OP: begin
               if (acc_r[31]) begin
                  acc_nxt = 32'h0000_0000 - acc_r;
               end
            end
            accum_pkg::SUM_SHIFT_OP, accum_pkg::SUM_VARIABLE_SHIFT_OP,
            accum_pkg::SUM_LONG_IMMEDIATE_OP: begin
               sum = {1'b0, acc_r} + {1'b0, shifted};
               acc_nxt = sum[31:0];
               carry_nxt = sum[32];
            end
            accum_pkg::SUM_WITH_CARRY_OP: begin
               sum = {1'b0, acc_r} + {1'b0, mem_sx} + {32'h0000_0000, carry_r};
               acc_nxt = sum[31:0];
               carry_nxt = sum[32];
            end
            accum_pkg::SUM_UPPER_HALF_OP: begin
               hi_sum = {1'b0, acc_r[31:16]} + {1'b0, instr.mem_data};
               acc_nxt = {hi_sum[15:0], acc_r[15:0]};
               carry_nxt = hi_sum[16];
            end
            accum_pkg::SUM_SHORT_IMMEDIATE_OP: begin
               sum = {1'b0, acc_r} + {25'h000_0000, instr.imm[7:0]};
               acc_nxt = sum[31:0];
               carry_nxt = sum[32];
            end
            accum_pkg::SUM_UNSIGNED_OP: begin
               sum = {1'b0, acc_r} + {17'h0_0000, instr.mem_data};
               acc_nxt = sum[31:0];
               carry_nxt = sum[32];
            end
            accum_pkg::POINTER_INCREMENT_OP: begin
               ptr_we = 1'b1;
               ptr_wval = cur_ptr + {8'h00, instr.imm[7:0]};
            end
            accum_pkg::MASK_OP: begin
               acc_nxt = acc_r & (instr.use_imm ? shifted
                                                : {16'h0000, instr.mem_data});
            end
            accum_pkg::MASK_LONG_IMMEDIATE_OP: acc_nxt = acc_r & shifted;
            accum_pkg::PRODUCT_ACCUMULATE_OP: begin
               sum = {1'b0, acc_r} + {1'b0, prod_r << prod_shift_amt};
               acc_nxt = sum[31:0];
               carry_nxt = sum[32];
            end
            accum_pkg::BRANCH_OP: pc_nxt = instr.target;
            default: ;
         endcase
         // Any op with ind_en set and use_imm clear carries an indirect step, except the pointer add, magnitude and product accumulate.
         if (instr.ind_en && !instr.use_imm && instr.op != accum_pkg::POINTER_INCREMENT_OP &&
             instr.op != accum_pkg::MAGNITUDE_OP &&
             instr.op != accum_pkg::PRODUCT_ACCUMULATE_OP) begin
            ptr_we = 1'b1;
            ptr_wval = stepped;
            if (instr.select_load) begin
               current_pointer_select_nxt = instr.next_select;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         acc_r <= `RST_ACC;
         carry_r <= 1'b0;
         pc_r <= `RST_PC;
         current_pointer_select_r <= `RST_SELECT;
         done_r <= 1'b0;
      end else begin
         acc_r <= acc_nxt;
         carry_r <= carry_nxt;
         pc_r <= pc_nxt;
         current_pointer_select_r <= current_pointer_select_nxt;
         done_r <= op_valid;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   logic is_op;
   assign is_op = op_valid;

   property p_mag_neg;
      is_op && instr.op == accum_pkg::MAGNITUDE_OP && acc_r[31]
      |=> acc_r == 32'h0000_0000 - $past(acc_r);
   endproperty
   a_mag_neg: assert property (p_mag_neg) else $error("Magnitude wrong.");

   property p_mag_pos;
      is_op && instr.op == accum_pkg::MAGNITUDE_OP && !acc_r[31] |=> $stable(acc_r);
   endproperty
   a_mag_pos: assert property (p_mag_pos) else $error("Magnitude changed.");

   property p_carry_add;
      is_op && instr.op == accum_pkg::SUM_WITH_CARRY_OP
      |=> {carry_r, acc_r} == {1'b0, $past(acc_r)} + {1'b0, $past(mem_sx)}
                              + {32'h0000_0000, $past(carry_r)};
   endproperty
   a_carry_add: assert property (p_carry_add) else $error("Carry add wrong.");

   property p_upper;
      is_op && instr.op == accum_pkg::SUM_UPPER_HALF_OP
      |=> acc_r[15:0] == $past(acc_r[15:0]) &&
          {carry_r, acc_r[31:16]} == $past(acc_r[31:16]) + {1'b0, $past(instr.mem_data)};
   endproperty
   a_upper: assert property (p_upper) else $error("Upper add wrong.");

   property p_short;
      is_op && instr.op == accum_pkg::SUM_SHORT_IMMEDIATE_OP
      |=> acc_r == $past(acc_r) + {24'h00_0000, $past(instr.imm[7:0])};
   endproperty
   a_short: assert property (p_short) else $error("Short add wrong.");

   property p_unsigned;
      is_op && instr.op == accum_pkg::SUM_UNSIGNED_OP
      |=> acc_r == $past(acc_r) + {16'h0000, $past(instr.mem_data)};
   endproperty
   a_unsigned: assert property (p_unsigned) else $error("Unsigned add wrong.");

   property p_shift2;
      is_op && instr.op == accum_pkg::SUM_LONG_IMMEDIATE_OP |-> shift_sel <= `SHIFT2_MAX;
   endproperty
   a_shift2: assert property (p_shift2) else $error("Shift too long.");

   property p_mask_mem;
      is_op && instr.op == accum_pkg::MASK_OP && !instr.use_imm |=> acc_r[31:16] == 16'h0000;
   endproperty
   a_mask_mem: assert property (p_mask_mem) else $error("Upper not cleared.");

   // The selector is left alone by the pointer add, so the same pointer is read back.
   property p_ptr_inc;
      is_op && instr.op == accum_pkg::POINTER_INCREMENT_OP
      |=> cur_ptr == $past(cur_ptr) + {8'h00, $past(instr.imm[7:0])};
   endproperty
   a_ptr_inc: assert property (p_ptr_inc) else $error("Pointer add wrong.");

   property p_ptr_step;
      is_op && instr.op == accum_pkg::BRANCH_OP && instr.ind_en && !instr.use_imm &&
      instr.ind_mode == accum_pkg::IND_INC
      |=> pointer_register_bank[$past(current_pointer_select_r)] == $past(cur_ptr) + 16'h0001;
   endproperty
   a_ptr_step: assert property (p_ptr_step) else $error("Pointer step wrong.");

   property p_branch;
      is_op && instr.op == accum_pkg::BRANCH_OP |=> pc_r == $past(instr.target) && done_r;
   endproperty
   a_branch: assert property (p_branch) else $error("Branch wrong.");

   c_branch: cover property (is_op && instr.op == accum_pkg::BRANCH_OP && instr.select_load);
   c_carry: cover property (is_op && instr.op == accum_pkg::SUM_SHIFT_OP ##1 carry_r);
   c_bitrev: cover property (is_op && instr.ind_en && instr.ind_mode == accum_pkg::IND_BR_ADD0);
   c_pac: cover property (is_op && instr.op == accum_pkg::PRODUCT_ACCUMULATE_OP &&
                          product_shift_select_r == 2'h2);
endmodule : accumulator_arith_logic_datapath
`default_nettype wire

// File: verif/accumulator_arith_logic_datapath_test.sv
// Self-checking bench for the accumulator datapath: reset and register port reads, a table of chained
// operations, then product, branch and sign extension cases written by hand.
// Assumes the package and design files are compiled first; the bench drives every port.
`include "accum_map.svh"
`timescale 1ns/1ns
`default_nettype none
module accumulator_arith_logic_datapath_test;
   typedef struct packed {
      accum_pkg::instr_type ins;
      logic [31:0] acc;
      logic c;
   } row_type;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic op_valid = 1'b0;
   accum_pkg::instr_type instr = '0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata_r;
   logic [31:0] acc_r;
   logic carry_r;
   logic [15:0] pc_r;
   logic [2:0] current_pointer_select_r;
   logic done_r;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   accum_pkg::instr_type br;
   logic [4:0] pms [4] = '{`PROD_SHIFT0, `PROD_SHIFT1, `PROD_SHIFT2, `PROD_SHIFT3};

   function automatic accum_pkg::instr_type mk(input accum_pkg::op_type op, input logic ui,
      input logic [15:0] m, input logic [15:0] k, input logic [4:0] s);
      accum_pkg::instr_type t;
      t = '0;
      t.op = op;
      t.use_imm = ui;
      t.mem_data = m;
      t.imm = k;
      t.shift = s;
      return t;
   endfunction : mk

   // Each row starts from the accumulator that the row above left behind.
   row_type rows [18] = '{
      '{mk(accum_pkg::SUM_SHIFT_OP, 1'b0, 16'h8001, 16'h0, 5'h04), 32'hfff8_0010, 1'b0},
      '{mk(accum_pkg::MAGNITUDE_OP, 1'b0, 16'h0, 16'h0, 5'h00), 32'h0007_fff0, 1'b0},
      '{mk(accum_pkg::MAGNITUDE_OP, 1'b0, 16'h0, 16'h0, 5'h00), 32'h0007_fff0, 1'b0},
      '{mk(accum_pkg::SUM_UPPER_HALF_OP, 1'b0, 16'hfffa, 16'h0, 5'h0), 32'h0001_fff0, 1'b1},
      '{mk(accum_pkg::SUM_WITH_CARRY_OP, 1'b0, 16'h000f, 16'h0, 5'h0), 32'h0002_0000, 1'b0},
      '{mk(accum_pkg::SUM_UNSIGNED_OP, 1'b0, 16'hffff, 16'h0, 5'h00), 32'h0002_ffff, 1'b0},
      '{mk(accum_pkg::SUM_SHORT_IMMEDIATE_OP, 1'b1, 16'h0, 16'h81, 5'h0), 32'h0003_0080, 1'b0},
      '{mk(accum_pkg::SUM_LONG_IMMEDIATE_OP, 1'b1, 16'h0, 16'h8000, 5'hf), 32'hc003_0080, 1'b0},
      '{mk(accum_pkg::SUM_LONG_IMMEDIATE_OP, 1'b1, 16'h0, 16'h1, 5'h14), 32'hc003_8080, 1'b0},
      '{mk(accum_pkg::SUM_SHIFT_OP, 1'b1, 16'h0, 16'h0001, 5'h10), 32'hc004_8080, 1'b0},
      '{mk(accum_pkg::SUM_SHIFT_OP, 1'b0, 16'h4000, 16'h0, 5'h10), 32'h0004_8080, 1'b1},
      '{mk(accum_pkg::POINTER_INCREMENT_OP, 1'b1, 16'h0, 16'h12, 5'h0), 32'h0004_8080, 1'b1},
      '{mk(accum_pkg::MASK_LONG_IMMEDIATE_OP, 1'b1, 16'h0, 16'hff, 5'h4), 32'h0000_0080, 1'b1},
      '{mk(accum_pkg::SUM_UPPER_HALF_OP, 1'b0, 16'h1234, 16'h0, 5'h0), 32'h1234_0080, 1'b0},
      '{mk(accum_pkg::MASK_OP, 1'b0, 16'h00f0, 16'h0, 5'h00), 32'h0000_0080, 1'b0},
      '{mk(accum_pkg::SUM_UPPER_HALF_OP, 1'b0, 16'hffff, 16'h0, 5'h0), 32'hffff_0080, 1'b0},
      '{mk(accum_pkg::MASK_OP, 1'b1, 16'h0, 16'hffff, 5'h08), 32'h00ff_0000, 1'b0},
      '{mk(accum_pkg::OP_NONE, 1'b0, 16'hffff, 16'h0, 5'h00), 32'h00ff_0000, 1'b0}
   };

   accumulator_arith_logic_datapath #(.POINTERS(8)) u_dut (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .op_valid(op_valid),
      .instr(instr),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata_r(reg_rdata_r),
      .acc_r(acc_r),
      .carry_r(carry_r),
      .pc_r(pc_r),
      .current_pointer_select_r(current_pointer_select_r),
      .done_r(done_r)
   );

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : reg_write

   // Read data stand only in the cycle after the strobe, so both cycles are looked at.
   task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 check(reg_rdata_r, exp, "read data");
      @(posedge clk_sys);
      #1 check(reg_rdata_r, 32'h0, "read idle");
   endtask : reg_read

   task automatic issue(input accum_pkg::instr_type t, input logic [31:0] a, input logic c);
      @(posedge clk_sys);
      op_valid <= 1'b1;
      instr <= t;
      @(posedge clk_sys);
      op_valid <= 1'b0;
      #1 check(acc_r, a, "acc");
      check({31'h0, carry_r}, {31'h0, c}, "carry");
      check({31'h0, done_r}, 32'h1, "done");
   endtask : issue

   task automatic complete_run();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   // ----------------------------------------
   // Clock, watchdog and sequence
   // ----------------------------------------
   initial begin
      forever #25 clk_sys = ~clk_sys;
   end

   // The whole sequence needs about 120 cycles; the ceiling leaves a wide margin.
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fails = fails + 1;
         complete_run();
      end
   end

   initial begin
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      #1 check(acc_r | {31'h0, carry_r} | {16'h0, pc_r}, 32'h0, "reset outputs");
      check({28'h0, current_pointer_select_r, done_r}, 32'h0, "reset select");
      reg_read(`REG_CONTROL, {29'h0, `RST_PROD_SHIFT, `RST_SIGN_EXT});
      reg_read(`REG_STATUS, 32'h0);
      reg_read(`REG_PROD_LO, 32'h0);
      reg_read(`REG_TEMP, 32'h0);
      reg_read(4'hf, 32'h0);
      // Back-to-back issue: the next row is presented at the edge that takes this one.
      @(posedge clk_sys);
      op_valid <= 1'b1;
      instr <= rows[0].ins;
      for (int i = 0; i < 18; i++) begin
         @(posedge clk_sys);
         if (i < 17) instr <= rows[i + 1].ins;
         else op_valid <= 1'b0;
         #1 check(acc_r, rows[i].acc, "row acc");
         check({31'h0, carry_r}, {31'h0, rows[i].c}, "row carry");
         check({31'h0, done_r}, 32'h1, "row done");
      end
      @(posedge clk_sys);
      #1 check({31'h0, done_r}, 32'h0, "done idle");
      reg_write(`REG_PROD_LO, 32'h0000_0003);
      reg_write(`REG_PROD_HI, 32'h0000_0001);
      for (int p = 0; p < 4; p++) begin
         issue(mk(accum_pkg::MASK_OP, 1'b0, 16'h0, 16'h0, 5'h0), 32'h0, 1'b0);
         reg_write(`REG_CONTROL, {29'h0, 2'(p), 1'b1});
         reg_read(`REG_CONTROL, {29'h0, 2'(p), 1'b1});
         issue(mk(accum_pkg::PRODUCT_ACCUMULATE_OP, 1'b0, 16'h0, 16'h0, 5'h0),
            32'h0001_0003 << pms[p], 1'b0);
      end
      for (int m = 0; m < 8; m++) begin
         br = mk(accum_pkg::BRANCH_OP, 1'b0, 16'h0, 16'h0, 5'h0);
         br.target = 16'h0100 + 16'(m);
         br.ind_en = 1'b1;
         br.ind_mode = accum_pkg::ind_mode_type'(m);
         br.select_load = 1'b1;
         br.next_select = 3'(m) ^ 3'h5;
         issue(br, 32'h0001_0003, 1'b0);
         check({16'h0, pc_r}, 32'h0000_0100 + 32'(m), "pc");
         check({29'h0, current_pointer_select_r}, {29'h0, 3'(m) ^ 3'h5}, "select");
      end
      reg_read(`REG_STATUS, 32'h0000_0004);
      reg_write(`REG_ACC_LO, 32'h0000_ffff);
      reg_read(`REG_ACC_LO, 32'h0000_0003);
      reg_read(`REG_ACC_HI, 32'h0000_0001);
      reg_write(`REG_CONTROL, 32'h0);
      issue(mk(accum_pkg::MASK_OP, 1'b0, 16'h0, 16'h0, 5'h0), 32'h0, 1'b0);
      issue(mk(accum_pkg::SUM_SHIFT_OP, 1'b0, 16'h8001, 16'h0, 5'h4), 32'h0008_0010, 1'b0);
      reg_write(`REG_TEMP, 32'h0000_fff3);
      issue(mk(accum_pkg::SUM_VARIABLE_SHIFT_OP, 1'b0, 16'h8000, 16'h0, 5'h0),
         32'h000c_0010, 1'b0);
      reg_write(`REG_CONTROL, 32'h1);
      issue(mk(accum_pkg::SUM_VARIABLE_SHIFT_OP, 1'b0, 16'h8000, 16'h0, 5'h0),
         32'h0008_0010, 1'b1);
      issue(mk(accum_pkg::SUM_WITH_CARRY_OP, 1'b0, 16'h0, 16'h0, 5'h0), 32'h0008_0011, 1'b0);
      complete_run();
   end
endmodule : accumulator_arith_logic_datapath_test
`default_nettype wire
